/* File: hw/mtc_pkg.sv */
package mtc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [31:0] MTC_IDX_START = 32'hffff_8240;
  localparam logic [31:0] MTC_IDX_SYNC = 32'hffff_8241;
  localparam logic [31:0] MTC_IDX_CTRL = 32'hffff_82a0;
  localparam logic [31:0] MTC_IDX_PIN = 32'hffff_82a2;
  localparam logic [31:0] MTC_IDX_IRQEN = 32'hffff_82a4;
  localparam logic [31:0] MTC_IDX_FLAGS = 32'hffff_82a5;
  localparam logic [31:0] MTC_IDX_COUNT = 32'hffff_82a6;
  localparam logic [31:0] MTC_IDX_GRA = 32'hffff_82a8;
  localparam logic [31:0] MTC_IDX_GRB = 32'hffff_82aa;
  localparam int MTC_ADDR_W = 12;
  localparam int MTC_IDX_W = MTC_ADDR_W - 2;

  // Reset values
  localparam logic [7:0] MTC_RST_START = 8'h00;
  localparam logic [7:0] MTC_RST_SYNC = 8'h00;
  localparam logic [7:0] MTC_RST_CTRL = 8'h00;
  localparam logic [7:0] MTC_RST_PIN = 8'h00;
  localparam logic [7:0] MTC_RST_IRQEN = 8'h40;
  localparam logic [7:0] MTC_RST_FLAGS = 8'hc0;
  localparam logic [15:0] MTC_RST_COUNT = 16'h0000;
  localparam logic [15:0] MTC_RST_GR = 16'hffff;
  localparam logic [15:0] MTC_ALL_ONES = 16'hffff;
  localparam logic [15:0] MTC_ZERO = 16'h0000;

  // Field positions
  localparam int MTC_BIT_TRIG_EN = 7;
  localparam int MTC_BIT_UNF = 5;
  localparam int MTC_BIT_OVF = 4;
  localparam int MTC_BIT_MB = 1;
  localparam int MTC_BIT_MA = 0;
  localparam int MTC_BIT_DIR = 7;
  localparam int MTC_BIT_DOWN = 0;
  localparam int MTC_COUNTER_CLEAR_SELECT_LO = 5;
  localparam int MTC_CH = 2;
  localparam logic [7:0] MTC_IRQEN_WMASK = 8'hb3;
  localparam logic [7:0] MTC_CTRL_WMASK = 8'h61;
  localparam logic [7:0] MTC_CH_WMASK = 8'h07;

  // Counter clear sources
  localparam logic [1:0] MTC_COUNTER_CLEAR_SELECT_NONE = 2'h0;
  localparam logic [1:0] MTC_COUNTER_CLEAR_SELECT_A = 2'h1;
  localparam logic [1:0] MTC_COUNTER_CLEAR_SELECT_B = 2'h2;
  localparam logic [1:0] MTC_COUNTER_CLEAR_SELECT_SYNC = 2'h3;

  // Pin-control actions on compare match, and capture edge codes
  localparam logic [1:0] MTC_ACT_OFF = 2'h0;
  localparam logic [1:0] MTC_ACT_LOW = 2'h1;
  localparam logic [1:0] MTC_ACT_HIGH = 2'h2;
  localparam logic [1:0] MTC_ACT_TOGGLE = 2'h3;
  localparam logic [1:0] MTC_EDGE_RISE = 2'h0;
  localparam logic [1:0] MTC_EDGE_FALL = 2'h1;

  localparam logic [31:0] MTC_RDATA_ZERO = 32'h0000_0000;
endpackage

/* File: hw/mtc_channel.sv */
// Operation
// - Top bit set: capture on chosen edge
// - Trigger enable gates conversion start requests
// - Underflow request needs enable and flag
// - Overflow request needs enable and flag
// - Direction flag reads one when counting up
// - Wrap zero to all ones sets underflow
// - Wrap all ones to zero sets overflow
// - Flag clears by zero write after read
// - Match or capture sets match flag
// - DMA transfer clears match A flag
// - Start bit zero halts, one counts
// - Stopping keeps current compare pin level
// - Pin-control write while stopped sets initial level
// - Sync bit joins synchronous preset and clear
// - Clear field: none, A, B, synchronous
`timescale 1ns/100ps
`default_nettype none
module mtc_channel
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mtc_pkg::MTC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count clock enable from the prescaler
  input wire logic count_tick,
  // Timer pins
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  input wire logic timer_pin_b_in,
  output logic timer_pin_b_out,
  output logic timer_pin_b_oe,
  // Synchronous operation with the other channels
  output logic [2:0] channel_start_bits,
  output logic [2:0] channel_sync_bits,
  input wire logic sync_clear_in,
  input wire logic sync_preset_in,
  input wire logic [15:0] sync_preset_value,
  output logic sync_clear_out,
  output logic sync_preset_out,
  output logic [15:0] sync_preset_data,
  // DMA transfer caused by match A flag
  input wire logic dma_ack_a,
  // Requests
  output logic adc_start_req,
  output logic underflow_irq,
  output logic overflow_irq,
  output logic match_a_irq,
  output logic match_b_irq
);
  import mtc_pkg::*;

  function automatic logic hit(input logic [MTC_ADDR_W-1:0] a, input logic [31:0] idx);
    hit = (a[MTC_ADDR_W-1:2] == idx[MTC_IDX_W-1:0]);
  endfunction

  function automatic logic pin_level(input logic [3:0] f, input logic cur);
    case (f[1:0])
      MTC_ACT_LOW: pin_level = 1'b0;
      MTC_ACT_HIGH: pin_level = 1'b1;
      MTC_ACT_TOGGLE: pin_level = ~cur;
      default: pin_level = cur;
    endcase
  endfunction

  function automatic logic cap_edge(input logic [1:0] sel, input logic now, input logic was);
    case (sel)
      MTC_EDGE_RISE: cap_edge = now & ~was;
      MTC_EDGE_FALL: cap_edge = ~now & was;
      default: cap_edge = now ^ was;
    endcase
  endfunction

  logic [7:0] start_reg;
  logic [7:0] sync_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] pin_io_control;
  logic [7:0] irq_en;
  logic [7:0] flags;
  logic [3:0] read_armed;
  logic [15:0] channel_counter;
  logic [15:0] general_reg_a;
  logic [15:0] general_reg_b;
  logic moved;
  logic [2:0] pa_sync;
  logic [2:0] pb_sync;

  // Bus decode
  logic wr;
  logic rd;
  logic mapped;
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & pready & ~pwrite;
  assign mapped = hit(paddr, MTC_IDX_START) | hit(paddr, MTC_IDX_SYNC) |
                  hit(paddr, MTC_IDX_CTRL) | hit(paddr, MTC_IDX_PIN) |
                  hit(paddr, MTC_IDX_IRQEN) | hit(paddr, MTC_IDX_FLAGS) |
                  hit(paddr, MTC_IDX_COUNT) | hit(paddr, MTC_IDX_GRA) |
                  hit(paddr, MTC_IDX_GRB);

  logic running;
  logic count_down;
  logic [1:0] counter_clear_select;
  logic [3:0] pin_ctrl_a_field;
  logic [3:0] pin_ctrl_b_field;
  logic cap_a_mode;
  logic cap_b_mode;
  assign running = start_reg[MTC_CH];
  assign count_down = ctrl_reg[MTC_BIT_DOWN];
  assign counter_clear_select = ctrl_reg[MTC_COUNTER_CLEAR_SELECT_LO+1:MTC_COUNTER_CLEAR_SELECT_LO];
  assign pin_ctrl_a_field = pin_io_control[3:0];
  assign pin_ctrl_b_field = pin_io_control[7:4];
  assign cap_a_mode = pin_ctrl_a_field[3];
  assign cap_b_mode = pin_ctrl_b_field[3];

  // Events
  logic step;
  logic cmp_a;
  logic cmp_b;
  logic capt_a;
  logic capt_b;
  logic ev_a;
  logic ev_b;
  logic ev_unf;
  logic ev_ovf;
  logic own_clear;
  logic do_clear;
  logic wr_count;
  assign step = running & count_tick;
  assign cmp_a = ~cap_a_mode & moved & (channel_counter == general_reg_a);
  assign cmp_b = ~cap_b_mode & moved & (channel_counter == general_reg_b);
  assign capt_a = cap_a_mode & cap_edge(pin_ctrl_a_field[1:0], pa_sync[1], pa_sync[2]);
  assign capt_b = cap_b_mode & cap_edge(pin_ctrl_b_field[1:0], pb_sync[1], pb_sync[2]);
  assign ev_a = cmp_a | capt_a;
  assign ev_b = cmp_b | capt_b;
  assign ev_unf = step & count_down & (channel_counter == MTC_ZERO);
  assign ev_ovf = step & ~count_down & (channel_counter == MTC_ALL_ONES);
  assign own_clear = (counter_clear_select == MTC_COUNTER_CLEAR_SELECT_A & ev_a) |
                     (counter_clear_select == MTC_COUNTER_CLEAR_SELECT_B & ev_b);
  // Synchronous clear only when this channel has joined the group
  assign do_clear = own_clear |
                    (counter_clear_select == MTC_COUNTER_CLEAR_SELECT_SYNC & sync_reg[MTC_CH] &
                     sync_clear_in);
  assign wr_count = wr & hit(paddr, MTC_IDX_COUNT);

  // Interrupt requests follow an enable write at once; adc_start_req uses irq_en, a cycle late
  logic [7:0] next_irq_en;
  assign next_irq_en = (wr & hit(paddr, MTC_IDX_IRQEN)) ?
      ((pwdata[7:0] & MTC_IRQEN_WMASK) | (MTC_RST_IRQEN & ~MTC_IRQEN_WMASK)) : irq_en;

  // APB: one wait-free access phase, ready registered from setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= MTC_RDATA_ZERO;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      if (psel & ~penable & ~pready & ~pwrite) begin
        prdata <= MTC_RDATA_ZERO;
        if (hit(paddr, MTC_IDX_START)) prdata[7:0] <= start_reg;
        if (hit(paddr, MTC_IDX_SYNC)) prdata[7:0] <= sync_reg;
        if (hit(paddr, MTC_IDX_CTRL)) prdata[7:0] <= ctrl_reg;
        if (hit(paddr, MTC_IDX_PIN)) prdata[7:0] <= pin_io_control;
        if (hit(paddr, MTC_IDX_IRQEN)) prdata[7:0] <= irq_en;
        if (hit(paddr, MTC_IDX_FLAGS)) prdata[7:0] <= flags;
        if (hit(paddr, MTC_IDX_COUNT)) prdata[15:0] <= channel_counter;
        if (hit(paddr, MTC_IDX_GRA)) prdata[15:0] <= general_reg_a;
        if (hit(paddr, MTC_IDX_GRB)) prdata[15:0] <= general_reg_b;
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= MTC_RST_START;
      sync_reg <= MTC_RST_SYNC;
      ctrl_reg <= MTC_RST_CTRL;
      irq_en <= MTC_RST_IRQEN;
    end else if (wr) begin
      if (hit(paddr, MTC_IDX_START)) start_reg <= pwdata[7:0] & MTC_CH_WMASK;
      if (hit(paddr, MTC_IDX_SYNC)) sync_reg <= pwdata[7:0] & MTC_CH_WMASK;
      if (hit(paddr, MTC_IDX_CTRL)) ctrl_reg <= pwdata[7:0] & MTC_CTRL_WMASK;
      if (hit(paddr, MTC_IDX_IRQEN)) irq_en <= next_irq_en;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_io_control <= MTC_RST_PIN;
    end else if (wr & hit(paddr, MTC_IDX_PIN)) begin
      pin_io_control <= pwdata[7:0];
    end
  end

  // Counter: bus write, then sync preset, then clear, then step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_counter <= MTC_RST_COUNT;
      moved <= 1'b0;
    end else begin
      moved <= wr_count | do_clear | step | (sync_preset_in & sync_reg[MTC_CH]);
      if (wr_count) begin
        channel_counter <= pwdata[15:0];
      end else if (sync_preset_in & sync_reg[MTC_CH]) begin
        channel_counter <= sync_preset_value;
      end else if (do_clear) begin
        channel_counter <= MTC_ZERO;
      end else if (step) begin
        channel_counter <= count_down ? channel_counter - 16'h0001 :
                                        channel_counter + 16'h0001;
      end
    end
  end

  // Sync announcements to other channels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_clear_out <= 1'b0;
      sync_preset_out <= 1'b0;
      sync_preset_data <= MTC_ZERO;
    end else begin
      sync_clear_out <= own_clear & sync_reg[MTC_CH];
      sync_preset_out <= wr_count & sync_reg[MTC_CH];
      if (wr_count) sync_preset_data <= pwdata[15:0];
    end
  end

  // General registers; capture beats a same-cycle bus write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      general_reg_a <= MTC_RST_GR;
    end else if (capt_a) begin
      general_reg_a <= channel_counter;
    end else if (wr & hit(paddr, MTC_IDX_GRA)) begin
      general_reg_a <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      general_reg_b <= MTC_RST_GR;
    end else if (capt_b) begin
      general_reg_b <= channel_counter;
    end else if (wr & hit(paddr, MTC_IDX_GRB)) begin
      general_reg_b <= pwdata[15:0];
    end
  end

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_sync <= 3'h0;
      pb_sync <= 3'h0;
    end else begin
      pa_sync <= {pa_sync[1:0], timer_pin_a_in};
      pb_sync <= {pb_sync[1:0], timer_pin_b_in};
    end
  end

  // Status flags with read-then-write-zero clear; set wins
  logic flags_wr;
  logic [3:0] ev_vec;
  logic [3:0] clr_vec;
  logic [3:0] next_flag;
  assign flags_wr = wr & hit(paddr, MTC_IDX_FLAGS);
  assign ev_vec = {ev_unf, ev_ovf, ev_b, ev_a};
  always_comb begin
    clr_vec = {4{flags_wr}} & read_armed &
              ~{pwdata[MTC_BIT_UNF], pwdata[MTC_BIT_OVF], pwdata[MTC_BIT_MB],
                pwdata[MTC_BIT_MA]};
    clr_vec[0] = clr_vec[0] | dma_ack_a;
    next_flag = ev_vec |
                ({flags[MTC_BIT_UNF], flags[MTC_BIT_OVF], flags[MTC_BIT_MB],
                  flags[MTC_BIT_MA]} & ~clr_vec);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= MTC_RST_FLAGS;
      read_armed <= 4'h0;
    end else begin
      flags[MTC_BIT_DIR] <= ~count_down;
      flags[MTC_BIT_UNF] <= next_flag[3];
      flags[MTC_BIT_OVF] <= next_flag[2];
      flags[MTC_BIT_MB] <= next_flag[1];
      flags[MTC_BIT_MA] <= next_flag[0];
      // Arming only from a read that saw the flag at one
      if (rd & hit(paddr, MTC_IDX_FLAGS)) begin
        read_armed <= {prdata[MTC_BIT_UNF], prdata[MTC_BIT_OVF], prdata[MTC_BIT_MB],
                       prdata[MTC_BIT_MA]} & next_flag;
      end else begin
        read_armed <= read_armed & next_flag & ~{4{flags_wr}};
      end
    end
  end

  // Request outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      underflow_irq <= 1'b0;
      overflow_irq <= 1'b0;
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
      adc_start_req <= 1'b0;
    end else begin
      underflow_irq <= next_irq_en[MTC_BIT_UNF] & next_flag[3];
      overflow_irq <= next_irq_en[MTC_BIT_OVF] & next_flag[2];
      match_b_irq <= next_irq_en[MTC_BIT_MB] & next_flag[1];
      match_a_irq <= next_irq_en[MTC_BIT_MA] & next_flag[0];
      adc_start_req <= irq_en[MTC_BIT_TRIG_EN] & ev_a;
    end
  end

  // Pin outputs; stopping the counter leaves the level alone
  logic pin_wr;
  logic [3:0] new_a;
  logic [3:0] new_b;
  assign pin_wr = wr & hit(paddr, MTC_IDX_PIN);
  assign new_a = pwdata[3:0];
  assign new_b = pwdata[7:4];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_a_out <= 1'b0;
      timer_pin_a_oe <= 1'b0;
    end else if (pin_wr) begin
      timer_pin_a_oe <= ~new_a[3] & (new_a[1:0] != MTC_ACT_OFF);
      if (!running) timer_pin_a_out <= new_a[2];
    end else if (cmp_a & ~pin_ctrl_a_field[3] & timer_pin_a_oe) begin
      timer_pin_a_out <= pin_level(pin_ctrl_a_field, timer_pin_a_out);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_b_out <= 1'b0;
      timer_pin_b_oe <= 1'b0;
    end else if (pin_wr) begin
      timer_pin_b_oe <= ~new_b[3] & (new_b[1:0] != MTC_ACT_OFF);
      if (!running) timer_pin_b_out <= new_b[2];
    end else if (cmp_b & ~pin_ctrl_b_field[3] & timer_pin_b_oe) begin
      timer_pin_b_out <= pin_level(pin_ctrl_b_field, timer_pin_b_out);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_start_bits <= 3'h0;
      channel_sync_bits <= 3'h0;
    end else begin
      channel_start_bits <= start_reg[2:0];
      channel_sync_bits <= sync_reg[2:0];
    end
  end
endmodule
`default_nettype wire

/* File: sim/mtc_pin_env.sv */
`timescale 1ns/100ps
`default_nettype none
module mtc_pin_env (
  // Pin drivers of the channel
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // Level the outside circuit puts on pin b
  input wire logic b_drive,
  // Resolved pin levels
  output logic a_line,
  output logic b_line
);
  // Pin a only has a pull-up outside; pin b's driver yields to the channel
  assign a_line = a_oe ? a_out : 1'b1;
  assign b_line = b_oe ? b_out : b_drive;
endmodule
`default_nettype wire

/* File: sim/mtc_channel_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module mtc_channel_chk
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mtc_pkg::MTC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Watched outputs
  input wire logic timer_pin_a_out,
  input wire logic timer_pin_a_oe,
  input wire logic adc_start_req,
  input wire logic underflow_irq,
  input wire logic overflow_irq,
  input wire logic match_a_irq,
  input wire logic match_b_irq
);
  logic wr;
  logic st;
  logic [7:0] en_q;
  logic [2:0] wr_hist;
  assign wr = psel && penable && pready && pwrite;
  function automatic logic at(input logic [31:0] idx);
    return paddr == {idx[MTC_IDX_W-1:0], 2'b00};
  endfunction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= MTC_RST_IRQEN;
    end else if (wr && at(MTC_IDX_IRQEN)) begin
      en_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= MTC_RST_START[MTC_CH];
    end else if (wr && at(MTC_IDX_START)) begin
      st <= pwdata[MTC_CH];
    end
  end
  // Any write may move the pin, so quiet spans exclude them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hist <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[1:0], wr};
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_adc_enable_gate: assert property (
    adc_start_req |-> en_q[MTC_BIT_TRIG_EN] || $past(en_q[MTC_BIT_TRIG_EN]))
    else $error("conversion request while disabled");
  chk_unf_irq_gate: assert property (underflow_irq |-> en_q[MTC_BIT_UNF])
    else $error("underflow request while disabled");
  chk_ovf_irq_gate: assert property (overflow_irq |-> en_q[MTC_BIT_OVF])
    else $error("overflow request while disabled");
  chk_ma_irq_gate: assert property (match_a_irq |-> en_q[MTC_BIT_MA])
    else $error("match a request while disabled");
  chk_mb_irq_gate: assert property (match_b_irq |-> en_q[MTC_BIT_MB])
    else $error("match b request while disabled");
  chk_stop_holds_pin: assert property (
    !st && $past(st, 3) == 1'b0 && wr_hist == 3'h0 |-> $stable(timer_pin_a_out))
    else $error("pin moved while stopped");
  chk_pin_init_level: assert property (
    wr && at(MTC_IDX_PIN) && !st && pwdata[1:0] != 2'h0 && !pwdata[3]
    |-> ##2 timer_pin_a_oe && timer_pin_a_out == $past(pwdata[2], 2))
    else $error("wrong initial pin level");
endmodule
bind mtc_channel mtc_channel_chk chk_i (
  .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .timer_pin_a_out, .timer_pin_a_oe, .adc_start_req,
  .underflow_irq, .overflow_irq, .match_a_irq, .match_b_irq
);
`default_nettype wire

/* File: sim/multi_channel_timer_channel_two_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module multi_channel_timer_channel_two_tb;
  import mtc_pkg::*;
  typedef struct {logic [31:0] idx; logic [31:0] rst; logic [31:0] wv; logic [31:0] exp;
    logic e;} mtc_row_t;
  logic mclk, rst_n, psel, penable, pwrite, tick, s_clr, s_pre, dma, b_drive, err;
  logic a_out, a_oe, b_out, b_oe, a_line, b_line, pready, pslverr;
  logic adc, unf_irq, ovf_irq, ma_irq, mb_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cst, csy;
  logic s_clr_o, s_pre_o;
  logic [15:0] s_pre_d;
  int n_mismatch, compares, n_adc, n_sclr, n_pre, i;
  mtc_row_t rows [10] = '{
    '{MTC_IDX_START, 8'h00, 8'hff, 8'h07, 1'b0}, '{MTC_IDX_SYNC, 8'h00, 8'hff, 8'h07, 1'b0},
    '{MTC_IDX_FLAGS, 8'hc0, 8'hff, 8'hc0, 1'b0}, '{MTC_IDX_CTRL, 8'h00, 8'hff, 8'h61, 1'b0},
    '{MTC_IDX_PIN, 8'h00, 8'h00, 8'h00, 1'b0}, '{MTC_IDX_IRQEN, 8'h40, 8'hff, 8'hf3, 1'b0},
    '{MTC_IDX_COUNT, 16'h0000, 16'h1234, 16'h1234, 1'b0},
    '{MTC_IDX_GRA, 16'hffff, 16'h0005, 16'h0005, 1'b0},
    '{MTC_IDX_GRB, 16'hffff, 16'h0008, 16'h0008, 1'b0},
    '{32'hffff_8250, 8'h00, 8'h12, 8'h00, 1'b1}};
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  mtc_channel dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .count_tick(tick), .timer_pin_a_in(a_line), .timer_pin_a_out(a_out),
    .timer_pin_a_oe(a_oe), .timer_pin_b_in(b_line), .timer_pin_b_out(b_out),
    .timer_pin_b_oe(b_oe), .channel_start_bits(cst), .channel_sync_bits(csy),
    .sync_clear_in(s_clr), .sync_preset_in(s_pre), .sync_preset_value(16'h1111),
    .sync_clear_out(s_clr_o), .sync_preset_out(s_pre_o), .sync_preset_data(s_pre_d),
    .dma_ack_a(dma), .adc_start_req(adc),
    .underflow_irq(unf_irq), .overflow_irq(ovf_irq), .match_a_irq(ma_irq),
    .match_b_irq(mb_irq));
  mtc_pin_env env (.a_out, .a_oe, .b_out, .b_oe, .b_drive, .a_line, .b_line);
  always @(posedge mclk) begin
    if (adc === 1'b1) begin
      n_adc++;
    end
    if (s_clr_o === 1'b1) begin
      n_sclr++;
    end
    if (s_pre_o === 1'b1) begin
      n_pre++;
    end
  end
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Idle edge at the end keeps psel from being driven twice in one step
  task automatic apb(input logic [31:0] idx, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[MTC_IDX_W-1:0], 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rdc(input string nm, input logic [31:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  task automatic run(input int n);
    wr(MTC_IDX_START, 8'h04);
    tick <= 1'b1;
    tk(n);
    tick <= 1'b0;
    wr(MTC_IDX_START, 8'h00);
  endtask
  initial begin
    {psel, penable, pwrite, tick, s_clr, s_pre, dma, b_drive} = '0;
    paddr = '0;
    pwdata = '0;
    n_mismatch = 0;
    compares = 0;
    n_adc = 0;
    n_sclr = 0;
    n_pre = 0;
    rst_n = 1'b0;
    tk(12);
    rst_n <= 1'b1;
    tk(1);
    foreach (rows[j]) begin
      rdc("reset value", rows[j].idx, rows[j].rst);
      wr(rows[j].idx, rows[j].wv);
      rdc("readback", rows[j].idx, rows[j].exp);
      chk("pslverr", rows[j].e, err);
    end
    chk("start sync bits", 6'h3f, {cst, csy});
    wr(MTC_IDX_START, 8'h00);
    wr(MTC_IDX_CTRL, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(MTC_IDX_PIN, {i[3:0], i[3:0]});
      tk(2);
      chk("pin oe", {2{i[1:0] != 2'h0}}, {a_oe, b_oe});
      if (i[1:0] != 2'h0) chk("pin level", {2{i[2]}}, {a_out, b_out});
    end
    wr(MTC_IDX_COUNT, 16'hfffe);
    wr(MTC_IDX_IRQEN, 8'h10);
    run(2);
    rdc("counter", MTC_IDX_COUNT, 16'h0000);
    rdc("flags", MTC_IDX_FLAGS, 8'hd0);
    chk("ovf irq", 1'b1, ovf_irq);
    wr(MTC_IDX_FLAGS, 8'hff);
    wr(MTC_IDX_FLAGS, 8'h00);
    rdc("flags", MTC_IDX_FLAGS, 8'hd0);
    wr(MTC_IDX_FLAGS, 8'h00);
    rdc("flags", MTC_IDX_FLAGS, 8'hc0);
    chk("ovf irq", 1'b0, ovf_irq);
    wr(MTC_IDX_CTRL, 8'h01);
    wr(MTC_IDX_COUNT, 16'h0001);
    wr(MTC_IDX_IRQEN, 8'h20);
    run(2);
    rdc("counter", MTC_IDX_COUNT, 16'hffff);
    rdc("flags", MTC_IDX_FLAGS, 8'h60);
    chk("unf irq", 1'b1, unf_irq);
    wr(MTC_IDX_CTRL, 8'h20);
    wr(MTC_IDX_GRA, 16'h0003);
    wr(MTC_IDX_COUNT, 16'h0000);
    wr(MTC_IDX_PIN, 8'h03);
    wr(MTC_IDX_IRQEN, 8'h81);
    n_adc = 0;
    n_sclr = 0;
    run(3);
    tk(4);
    chk("adc pulses", 1, n_adc);
    chk("match a irq", 1'b1, ma_irq);
    chk("pin a toggled", 1'b1, a_out);
    chk("sync clear out", 1, n_sclr);
    rdc("counter", MTC_IDX_COUNT, 16'h0000);
    dma <= 1'b1;
    tk(1);
    dma <= 1'b0;
    tk(2);
    chk("match a irq", 1'b0, ma_irq);
    wr(MTC_IDX_PIN, 8'h80);
    wr(MTC_IDX_COUNT, 16'h0040);
    wr(MTC_IDX_IRQEN, 8'h02);
    b_drive <= 1'b1;
    tk(8);
    rdc("capture rise", MTC_IDX_GRB, 16'h0040);
    chk("match b irq", 1'b1, mb_irq);
    wr(MTC_IDX_PIN, 8'h90);
    wr(MTC_IDX_COUNT, 16'h0050);
    b_drive <= 1'b0;
    tk(8);
    rdc("capture fall", MTC_IDX_GRB, 16'h0050);
    wr(MTC_IDX_CTRL, 8'h40);
    wr(MTC_IDX_PIN, 8'ha0);
    wr(MTC_IDX_COUNT, 16'h0060);
    b_drive <= 1'b1;
    tk(8);
    rdc("capture both", MTC_IDX_GRB, 16'h0060);
    rdc("clear on b", MTC_IDX_COUNT, 16'h0000);
    wr(MTC_IDX_SYNC, 8'h05);
    s_pre <= 1'b1;
    tk(1);
    s_pre <= 1'b0;
    tk(2);
    rdc("sync preset", MTC_IDX_COUNT, 16'h1111);
    n_pre = 0;
    wr(MTC_IDX_COUNT, 16'h0222);
    tk(1);
    chk("preset pulses", 1, n_pre);
    chk("preset data", 16'h0222, s_pre_d);
    wr(MTC_IDX_CTRL, 8'h60);
    s_clr <= 1'b1;
    tk(1);
    s_clr <= 1'b0;
    tk(2);
    rdc("sync clear", MTC_IDX_COUNT, 16'h0000);
    rst_n <= 1'b0;
    tk(2);
    chk("irqs in reset", 4'h0, {unf_irq, ovf_irq, ma_irq, mb_irq});
    rst_n <= 1'b1;
    tk(1);
    rdc("flags", MTC_IDX_FLAGS, 8'hc0);
    rdc("gen a", MTC_IDX_GRA, 16'hffff);
    end_of_test();
  end
endmodule
`default_nettype wire
